/* File: usfc_pkg.sv */
`default_nettype none

// Shared register map, field positions, reset values and codes of the serial port block.
package usfc_pkg;

  // Byte offsets of the word registers on the bus.
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_CTRL_B  = 8'h08;
  localparam logic [7:0] OFS_FRAME   = 8'h0c;
  localparam logic [7:0] OFS_BAUD_LO = 8'h10;
  localparam logic [7:0] OFS_BAUD_HI = 8'h14;

  // Status register bits.
  localparam int ST_RX_DONE  = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FRAME_ER = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_PAR_ERR  = 2;
  localparam int ST_DBL_SPD  = 1;

  // Control register B bits.
  localparam int CB_TX_EN  = 3;
  localparam int CB_CSZ_HI = 2;
  localparam int CB_RX_B8  = 1;
  localparam int CB_TX_B8  = 0;

  // Frame format register fields.
  localparam int FR_MODE_LSB = 6;
  localparam int FR_PAR_LSB  = 4;
  localparam int FR_STOP     = 3;
  localparam int FR_CSZ_LSB  = 1;
  localparam int FR_POL      = 0;

  // Reset values.
  localparam logic [7:0]  FRAME_RST = 8'h06;
  localparam logic [11:0] BAUD_RST  = 12'h000;

  // Operating modes and parity codes.
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_RSVD  = 2'h2;
  localparam logic [1:0] MODE_MSPI  = 2'h3;
  localparam logic [1:0] PAR_OFF    = 2'h0;
  localparam logic [1:0] PAR_RSVD   = 2'h1;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] PAR_ODD    = 2'h3;

  // Oversampling ticks per bit, normal and double speed.
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;

  // Data bits per character; reserved codes fall back to eight bits.
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    logic [3:0] n;
    n = 4'h8;
    if (code == 3'h7) begin
      n = 4'h9;
    end else if (code[2] == 1'b0) begin
      n = 4'h5 + {2'h0, code[1:0]};
    end
    return n;
  endfunction

endpackage

`default_nettype wire

/* File: usfc_baud.sv */
`default_nettype none

// Baud prescaler: one tick every divisor+1 clocks; in synchronous mode each tick toggles the serial clock.
module usfc_baud (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic [11:0] divisor_in,
  input  wire logic        reload_in,
  input  wire logic        sync_mode_in,
  output logic             os_tick_out,
  output logic             xck_out,
  output logic             xck_rise_out,
  output logic             xck_fall_out
);

  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
    logic        xck;
    logic        rise;
    logic        fall;
  } usfc_baud_st_t;

  usfc_baud_st_t s_r;
  usfc_baud_st_t s_nxt;

  // A reload restarts the count at once, so a divisor loaded with a reload never waits out the old period.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    if (reload_in) begin
      s_nxt.cnt = divisor_in;
    end else if (s_r.cnt == 12'h000) begin
      s_nxt.cnt  = divisor_in;
      s_nxt.tick = 1'b1;
      if (sync_mode_in) begin
        s_nxt.xck  = ~s_r.xck;
        s_nxt.rise = ~s_r.xck;
        s_nxt.fall = s_r.xck;
      end
    end else begin
      s_nxt.cnt = s_r.cnt - 12'h001;
    end
    if (!sync_mode_in) begin
      s_nxt.xck = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign os_tick_out  = s_r.tick;
  assign xck_out      = s_r.xck;
  assign xck_rise_out = s_r.rise;
  assign xck_fall_out = s_r.fall;

endmodule

`default_nettype wire

/* File: usfc_rx.sv */
`default_nettype none

// Receiver: start detect, data, optional parity and one stop bit into a single holding buffer.
module usfc_rx (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       rxd_pin_in,
  input  wire logic       os_tick_in,
  input  wire logic [4:0] ticks_per_bit_in,
  input  wire logic       sync_mode_in,
  input  wire logic       sample_edge_in,
  input  wire logic [3:0] char_bits_in,
  input  wire logic [1:0] parity_mode_in,
  input  wire logic       pop_in,
  output logic [8:0]      data_out,
  output logic            valid_out,
  output logic            frame_err_out,
  output logic            parity_err_out,
  output logic            overrun_out
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usfc_rx_state_t;

  typedef struct packed {
    logic           sync1;
    logic           sync2;
    usfc_rx_state_t st;
    logic [4:0]     tcnt;
    logic [3:0]     bitn;
    logic [8:0]     sh;
    logic           par;
    logic           par_bad;
    logic [8:0]     buf_data;
    logic           valid;
    logic           fe;
    logic           pe;
    logic           dor;
  } usfc_rx_s_t;

  usfc_rx_s_t s_r;
  usfc_rx_s_t s_nxt;
  logic       samp;
  logic [4:0] tgt;

  // Async sampling lands mid-bit: half a bit after the falling start edge, then once per bit.
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = rxd_pin_in;
    s_nxt.sync2 = s_r.sync1;
    samp        = 1'b0;
    tgt         = (s_r.st == RX_START) ? (ticks_per_bit_in >> 1) - 5'h01 : ticks_per_bit_in - 5'h01;
    if (sync_mode_in) begin
      samp = sample_edge_in;
    end else if (os_tick_in) begin
      if (s_r.tcnt == tgt) begin
        samp       = 1'b1;
        s_nxt.tcnt = 5'h00;
      end else begin
        s_nxt.tcnt = s_r.tcnt + 5'h01;
      end
    end
    if (pop_in) begin
      s_nxt.valid = 1'b0;
      s_nxt.fe    = 1'b0;
      s_nxt.pe    = 1'b0;
      s_nxt.dor   = 1'b0;
    end
    case (s_r.st)
      RX_IDLE: begin
        s_nxt.tcnt    = 5'h00;
        s_nxt.bitn    = 4'h0;
        s_nxt.sh      = 9'h000;
        s_nxt.par     = 1'b0;
        s_nxt.par_bad = 1'b0;
        if (sync_mode_in ? (samp && !s_r.sync2) : !s_r.sync2) begin
          s_nxt.st = sync_mode_in ? RX_DATA : RX_START;
        end
      end
      RX_START: begin
        if (samp) begin
          s_nxt.st = s_r.sync2 ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (samp) begin
          s_nxt.sh[s_r.bitn] = s_r.sync2;
          s_nxt.par          = s_r.par ^ s_r.sync2;
          s_nxt.bitn         = s_r.bitn + 4'h1;
          if (s_r.bitn == char_bits_in - 4'h1) begin
            s_nxt.st = parity_mode_in[1] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (samp) begin
          s_nxt.par_bad = s_r.par ^ s_r.sync2 ^ parity_mode_in[0];
          s_nxt.st      = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is checked, whatever the transmit stop count is.
        if (samp) begin
          s_nxt.st = RX_IDLE;
          if (s_nxt.valid) begin
            s_nxt.dor = 1'b1;
          end else begin
            s_nxt.buf_data = s_r.sh;
            s_nxt.valid    = 1'b1;
            s_nxt.fe       = ~s_r.sync2;
            s_nxt.pe       = s_r.par_bad & parity_mode_in[1];
          end
        end
      end
      default: begin
        s_nxt.st = RX_IDLE;
      end
    endcase
  end

  // State register; the line idles high.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_r       <= '0;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out       = s_r.buf_data;
  assign valid_out      = s_r.valid;
  assign frame_err_out  = s_r.fe;
  assign parity_err_out = s_r.pe;
  assign overrun_out    = s_r.dor;

endmodule

`default_nettype wire

/* File: usfc_usart_top.sv */
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none

// Behaviour
// - While enabled, the transmitter drives the transmit pin; otherwise it releases it.
// - Disabling waits until shift register and transmit buffer are both empty.
// - Mode field: 00 async, 01 sync, 10 reserved, 11 master SPI.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// - With parity on, the transmitter computes and inserts parity per frame.
// - With parity on, the receiver checks parity and flags a mismatch.
// - Stop select zero sends one stop bit, one sends two.
// - The receiver ignores the stop-bit select.
// - Size code 000..011 gives 5..8 bits, 111 gives 9, others reserved.
// - Sync polarity 0: transmit on rising, sample on falling; 1 swaps both.
// - Baud divisor is 12 bits: high register bits 11:8, low register 7:0.
// - Writing the low divisor byte reloads the prescaler at once.
// - High divisor register bits 7:4 read zero; software writes zeros.
// - Double speed in async mode uses 8 ticks per bit instead of 16.
module usfc_usart_top (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        receive_data_pin_in,
  output logic             transmit_data_pin_out,
  output logic             transmit_data_oe_out,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_oe_out
);

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_DONE} usfc_tx_state_t;

  typedef struct packed {
    logic [7:0]     frame;
    logic           tx_en;
    logic           csz_hi;
    logic           tx_b8;
    logic           dbl_spd;
    logic [11:0]    baud;
    logic           tx_done;
    logic [8:0]     tx_buf;
    logic           tx_full;
    usfc_tx_state_t st;
    logic [4:0]     tcnt;
    logic [3:0]     bitn;
    logic [8:0]     sh;
    logic           par;
    logic           stop2;
    logic           owns;
    logic           txd;
    logic           xck_oe;
    logic           wr_pend;
    logic [7:0]     ap_addr;
    logic [31:0]    hrdata;
    logic           hready;
  } usfc_top_st_t;

  usfc_top_st_t s_r;
  usfc_top_st_t s_nxt;

  logic [1:0] mode;
  logic [1:0] par_mode;
  logic       sync_mode;
  logic [4:0] tpb;
  logic [3:0] nbits;
  logic       os_tick;
  logic       xck;
  logic       xck_rise;
  logic       xck_fall;
  logic       tx_edge;
  logic       rx_edge;
  logic       step;
  logic       accept;
  logic       pop;
  logic       reload;
  logic [8:0] rx_data;
  logic       rx_valid;
  logic       rx_fe;
  logic       rx_pe;
  logic       rx_dor;
  logic [7:0] rd;

  // Frame configuration decode; reserved mode runs as asynchronous.
  assign mode      = s_r.frame[usfc_pkg::FR_MODE_LSB +: 2];
  assign par_mode  = s_r.frame[usfc_pkg::FR_PAR_LSB +: 2];
  assign sync_mode = (mode == usfc_pkg::MODE_SYNC) || (mode == usfc_pkg::MODE_MSPI);
  assign nbits     = usfc_pkg::char_bits({s_r.csz_hi, s_r.frame[usfc_pkg::FR_CSZ_LSB +: 2]});

  // Double speed only applies to asynchronous operation.
  assign tpb = (s_r.dbl_spd && !sync_mode) ? usfc_pkg::OS_DOUBLE : usfc_pkg::OS_NORMAL;

  // Clock edges per polarity: the transmitter changes on one edge, the receiver samples on the other.
  assign tx_edge = s_r.frame[usfc_pkg::FR_POL] ? xck_fall : xck_rise;
  assign rx_edge = s_r.frame[usfc_pkg::FR_POL] ? xck_rise : xck_fall;

  // Bus address phase taken only while no write is waiting for its data.
  assign accept = hsel_in && hready_in && htrans_in[1] && !s_r.wr_pend;
  assign pop    = accept && !hwrite_in && (haddr_in[7:0] == usfc_pkg::OFS_DATA);
  assign reload = s_r.wr_pend && (s_r.ap_addr == usfc_pkg::OFS_BAUD_LO);

  usfc_baud u_baud (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .divisor_in   (s_nxt.baud),
    .reload_in    (reload),
    .sync_mode_in (sync_mode),
    .os_tick_out  (os_tick),
    .xck_out      (xck),
    .xck_rise_out (xck_rise),
    .xck_fall_out (xck_fall)
  );

  usfc_rx u_rx (
    .clk_sys_in       (clk_sys_in),
    .sys_rst_in       (sys_rst_in),
    .rxd_pin_in       (receive_data_pin_in),
    .os_tick_in       (os_tick),
    .ticks_per_bit_in (tpb),
    .sync_mode_in     (sync_mode),
    .sample_edge_in   (rx_edge),
    .char_bits_in     (nbits),
    .parity_mode_in   (par_mode),
    .pop_in           (pop),
    .data_out         (rx_data),
    .valid_out        (rx_valid),
    .frame_err_out    (rx_fe),
    .parity_err_out   (rx_pe),
    .overrun_out      (rx_dor)
  );

  // Read mux. The ninth received bit is read without popping, so it is safe to read it first.
  always_comb begin
    rd = 8'h00;
    if (haddr_in[7:0] == usfc_pkg::OFS_DATA) begin
      rd = rx_data[7:0];
    end else if (haddr_in[7:0] == usfc_pkg::OFS_STATUS) begin
      rd[usfc_pkg::ST_RX_DONE]  = rx_valid;
      rd[usfc_pkg::ST_TX_DONE]  = s_r.tx_done;
      rd[usfc_pkg::ST_TX_EMPTY] = ~s_r.tx_full;
      rd[usfc_pkg::ST_FRAME_ER] = rx_fe;
      rd[usfc_pkg::ST_OVERRUN]  = rx_dor;
      rd[usfc_pkg::ST_PAR_ERR]  = rx_pe;
      rd[usfc_pkg::ST_DBL_SPD]  = s_r.dbl_spd;
    end else if (haddr_in[7:0] == usfc_pkg::OFS_CTRL_B) begin
      rd[usfc_pkg::CB_TX_EN]  = s_r.tx_en;
      rd[usfc_pkg::CB_CSZ_HI] = s_r.csz_hi;
      rd[usfc_pkg::CB_RX_B8]  = rx_data[8];
      rd[usfc_pkg::CB_TX_B8]  = s_r.tx_b8;
    end else if (haddr_in[7:0] == usfc_pkg::OFS_FRAME) begin
      rd = s_r.frame;
    end else if (haddr_in[7:0] == usfc_pkg::OFS_BAUD_LO) begin
      rd = s_r.baud[7:0];
    end else if (haddr_in[7:0] == usfc_pkg::OFS_BAUD_HI) begin
      rd = {4'h0, s_r.baud[11:8]};
    end
  end

  // Transmit bit strobe: oversample count in async mode, the change edge in sync mode.
  always_comb begin
    step = 1'b0;
    if (sync_mode) begin
      step = tx_edge;
    end else if (os_tick && (s_r.tcnt == tpb - 5'h01)) begin
      step = 1'b1;
    end
  end

  // Next state: bus slave, register writes, transmitter and pin ownership.
  always_comb begin
    s_nxt        = s_r;
    s_nxt.xck_oe = sync_mode;
    if (os_tick && !sync_mode) begin
      s_nxt.tcnt = step ? 5'h00 : s_r.tcnt + 5'h01;
    end

    // Writes cost one wait state so a following read never sees stale data.
    if (s_r.wr_pend) begin
      s_nxt.wr_pend = 1'b0;
      s_nxt.hready  = 1'b1;
      if (s_r.ap_addr == usfc_pkg::OFS_DATA) begin
        if (!s_r.tx_full) begin
          s_nxt.tx_buf  = {s_r.tx_b8, hwdata_in[7:0]};
          s_nxt.tx_full = 1'b1;
        end
      end else if (s_r.ap_addr == usfc_pkg::OFS_STATUS) begin
        s_nxt.dbl_spd = hwdata_in[usfc_pkg::ST_DBL_SPD];
        if (hwdata_in[usfc_pkg::ST_TX_DONE]) begin
          s_nxt.tx_done = 1'b0;
        end
      end else if (s_r.ap_addr == usfc_pkg::OFS_CTRL_B) begin
        s_nxt.tx_en  = hwdata_in[usfc_pkg::CB_TX_EN];
        s_nxt.csz_hi = hwdata_in[usfc_pkg::CB_CSZ_HI];
        s_nxt.tx_b8  = hwdata_in[usfc_pkg::CB_TX_B8];
      end else if (s_r.ap_addr == usfc_pkg::OFS_FRAME) begin
        s_nxt.frame = hwdata_in[7:0];
      end else if (s_r.ap_addr == usfc_pkg::OFS_BAUD_LO) begin
        s_nxt.baud[7:0] = hwdata_in[7:0];
      end else if (s_r.ap_addr == usfc_pkg::OFS_BAUD_HI) begin
        s_nxt.baud[11:8] = hwdata_in[3:0];
      end
    end else if (accept) begin
      if (hwrite_in) begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.ap_addr = haddr_in[7:0];
        s_nxt.hready  = 1'b0;
      end else begin
        s_nxt.hrdata = {24'h000000, rd};
      end
    end

    // Transmitter frame sequencer; each step emits the bit named by the state.
    case (s_r.st)
      TX_IDLE: begin
        s_nxt.txd = 1'b1;
        if (s_r.owns && s_r.tx_full) begin
          s_nxt.sh      = s_r.tx_buf;
          s_nxt.tx_full = 1'b0;
          s_nxt.st      = TX_START;
        end
      end
      TX_START: begin
        if (step) begin
          s_nxt.txd  = 1'b0;
          s_nxt.bitn = 4'h0;
          s_nxt.par  = 1'b0;
          s_nxt.st   = TX_DATA;
        end
      end
      TX_DATA: begin
        if (step) begin
          s_nxt.txd  = s_r.sh[s_r.bitn];
          s_nxt.par  = s_r.par ^ s_r.sh[s_r.bitn];
          s_nxt.bitn = s_r.bitn + 4'h1;
          if (s_r.bitn == nbits - 4'h1) begin
            s_nxt.st = par_mode[1] ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (step) begin
          s_nxt.txd = s_r.par ^ par_mode[0];
          s_nxt.st  = TX_STOP;
        end
      end
      TX_STOP: begin
        if (step) begin
          s_nxt.txd   = 1'b1;
          s_nxt.stop2 = s_r.frame[usfc_pkg::FR_STOP] && !s_r.stop2;
          s_nxt.st    = s_nxt.stop2 ? TX_STOP : TX_DONE;
        end
      end
      TX_DONE: begin
        // A waiting character starts right at the end of the stop bit, with no idle gap.
        if (step) begin
          if (s_r.owns && s_r.tx_full) begin
            s_nxt.sh      = s_r.tx_buf;
            s_nxt.tx_full = 1'b0;
            s_nxt.txd     = 1'b0;
            s_nxt.bitn    = 4'h0;
            s_nxt.par     = 1'b0;
            s_nxt.st      = TX_DATA;
          end else begin
            s_nxt.st      = TX_IDLE;
            s_nxt.tx_done = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = TX_IDLE;
      end
    endcase

    // Pin ownership: taken at once, released only once nothing is left to send.
    if (s_nxt.tx_en) begin
      s_nxt.owns = 1'b1;
    end else if (s_r.owns && (s_nxt.st == TX_IDLE) && !s_nxt.tx_full) begin
      s_nxt.owns = 1'b0;
    end
  end

  // State register; reset gives the default asynchronous 8N1 frame.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_r        <= '0;
      s_r.frame  <= usfc_pkg::FRAME_RST;
      s_r.baud   <= usfc_pkg::BAUD_RST;
      s_r.txd    <= 1'b1;
      s_r.hready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata_out            = s_r.hrdata;
  assign hreadyout_out         = s_r.hready;
  assign hresp_out             = 1'b0;
  assign transmit_data_pin_out = s_r.txd;
  assign transmit_data_oe_out  = s_r.owns;
  assign serial_clock_pin_out  = xck;
  assign serial_clock_oe_out   = s_r.xck_oe;

endmodule

`default_nettype wire

/* File: usfc_chk_sva.sv */
`default_nettype none

// Bus and pin checks on the top ports.
module usfc_chk (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        transmit_data_pin_out,
  input wire logic        transmit_data_oe_out,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  // Taken only while the slave is ready.
  sequence rd_take;
    hsel_in && hready_in && htrans_in[1] && !hwrite_in && hreadyout_out;
  endsequence
  sequence wr_take;
    hsel_in && hready_in && htrans_in[1] && hwrite_in && hreadyout_out;
  endsequence
  sequence wr_wait;
    !hreadyout_out ##1 hreadyout_out;
  endsequence

  read_no_wait_a: assert property (rd_take |=> hreadyout_out) else $error("read answered with a wait state");
  write_one_wait_a: assert property (wr_take |=> wr_wait) else $error("write wait not one cycle");
  okay_resp_a: assert property (hresp_out == 1'b0) else $error("response other than okay");
  upper_zero_a: assert property (hrdata_out[31:8] == 24'h0) else $error("read data above bit 7 not zero");
  reset_idle_a: assert property ($fell(sys_rst_in) |-> transmit_data_pin_out && !transmit_data_oe_out && !serial_clock_oe_out) else $error("pins not idle after reset");
  start_owned_a: assert property ($fell(transmit_data_pin_out) |-> transmit_data_oe_out) else $error("line driven low while released");
  release_idle_a: assert property ($fell(transmit_data_oe_out) |-> transmit_data_pin_out) else $error("pin released in mid frame");
  clock_quiet_a: assert property (!serial_clock_oe_out |-> !serial_clock_pin_out) else $error("serial clock moves while not driven");
  clock_owned_a: assert property ($rose(serial_clock_pin_out) |-> serial_clock_oe_out) else $error("serial clock rose outside clocked modes");
endmodule

`default_nettype wire

/* File: usfc_peer.sv */
`default_nettype none

// Far-end serial port.
module usfc_peer (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cyc  = 0;
  logic last = 1'b1;

  initial rxd_out = 1'b1;

  // Cycle count and the line's last level.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    last <= txd_in;
  end

  // Sends a frame, then rests at mark.
  task automatic send(input logic [12:0] f, input int len, input int bc);
    for (int k = 0; k < len; k++) begin
      rxd_out <= f[k];
      repeat (bc) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask

  // Waits for a start edge, then samples each bit at its centre.
  task automatic grab(input int len, input int bc, output logic [12:0] f, output int t0);
    f = '1;
    do begin
      @(posedge clk_in);
    end while (!(last === 1'b1 && txd_in === 1'b0));
    t0 = cyc;
    repeat (bc / 2) @(posedge clk_in);
    for (int k = 0; k < len; k++) begin
      if (k > 0) begin
        repeat (bc) @(posedge clk_in);
      end
      f[k] = txd_in;
    end
  endtask
endmodule

`default_nettype wire

/* File: usart_frame_config_baud_tb.sv */
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module usart_frame_config_baud_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [31:0] haddr      = '0;
  logic [31:0] hwdata     = '0;
  logic [1:0]  htrans     = '0;
  logic        hwrite     = 1'b0;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic        txd;
  logic        txd_oe;
  logic        xck;
  logic        xck_oe;
  logic        rxd;
  int          err_total  = 0;
  int          n_checks   = 0;
  int          cyc        = 0;

  usfc_usart_top u_usfc_usart_top (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .receive_data_pin_in(rxd), .transmit_data_pin_out(txd),
    .transmit_data_oe_out(txd_oe), .serial_clock_pin_out(xck), .serial_clock_oe_out(xck_oe));
  usfc_peer u_usfc_peer (.clk_in(clk_sys_in), .txd_in(txd), .rxd_out(rxd));

  // 10 MHz system clock.
  always #50 clk_sys_in = ~clk_sys_in;

  // Hang guard.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One word transfer; each phase held until ready.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys_in); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys_in); while (hrdy !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  // Frame line image, start bit first.
  function automatic logic [12:0] mk(input logic [8:0] d, input int n, input logic [1:0] par, input int ns,
                                     output int len);
    logic [12:0] f;
    logic        p;
    f = '1;
    f[0] = 1'b0;
    p = par[0];
    for (int k = 0; k < n; k++) begin
      f[k + 1] = d[k];
      p = p ^ d[k];
    end
    if (par[1]) begin
      f[n + 1] = p;
    end
    len = n + 1 + ns + (par[1] ? 1 : 0);
    return f;
  endfunction

  task automatic t_reset();
    logic [31:0] r;
    bus_rd(usfc_pkg::OFS_FRAME, r);
    `CHK(r, 32'h06)
    bus_rd(usfc_pkg::OFS_BAUD_LO, r);
    `CHK(r, 32'h0)
    bus_rd(usfc_pkg::OFS_CTRL_B, r);
    `CHK(r[3], 1'b0)
    `CHK(txd_oe, 1'b0)
  endtask

  // Divisor registers and an unmapped offset; divisor left at one while idle.
  task automatic t_regs();
    logic [31:0] r;
    bus_wr(usfc_pkg::OFS_BAUD_HI, 8'hff);
    bus_rd(usfc_pkg::OFS_BAUD_HI, r);
    `CHK(r, 32'h0f)
    bus_wr(usfc_pkg::OFS_BAUD_LO, 8'h5a);
    bus_rd(usfc_pkg::OFS_BAUD_LO, r);
    `CHK(r, 32'h5a)
    bus_wr(8'h18, 8'hff);
    bus_rd(8'h18, r);
    `CHK(r, 32'h0)
    bus_wr(usfc_pkg::OFS_BAUD_HI, 8'h00);
    bus_wr(usfc_pkg::OFS_BAUD_LO, 8'h01);
  endtask

  // Clocked modes drive the serial clock.
  task automatic t_modes();
    time t1;
    for (int m = 0; m < 4; m++) begin
      bus_wr(usfc_pkg::OFS_FRAME, {2'(m), 6'h06});
      repeat (3) @(posedge clk_sys_in);
      `CHK(xck_oe, 1'(m))
      if (m == 1) begin
        @(posedge xck);
        t1 = $time;
        @(posedge xck);
        `CHK($time - t1, 64'd400)
        @(posedge clk_sys_in);
      end
    end
    bus_wr(usfc_pkg::OFS_FRAME, 8'h06);
  endtask

  // Two frames per format; enable cleared while both pend.
  task automatic t_tx();
    logic [2:0]  csz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [1:0]  pm [5]  = '{usfc_pkg::PAR_EVEN, usfc_pkg::PAR_OFF, usfc_pkg::PAR_EVEN, usfc_pkg::PAR_ODD,
                             usfc_pkg::PAR_OFF};
    logic        sb [5]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic        dbl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [8:0]  d;
    logic [12:0] e;
    logic [12:0] f1;
    logic [12:0] f2;
    int          len;
    int          bc;
    int          t1;
    int          t2;
    for (int k = 0; k < 5; k++) begin
      d = 9'h1d3 - 9'(k * 61);
      bc = dbl[k] ? 16 : 32;
      e = mk(d, k == 4 ? 9 : k + 5, pm[k], sb[k] ? 2 : 1, len);
      bus_wr(usfc_pkg::OFS_STATUS, {6'h0, dbl[k], 1'b0});
      bus_wr(usfc_pkg::OFS_FRAME, {2'h0, pm[k], sb[k], csz[k][1:0], 1'b0});
      bus_wr(usfc_pkg::OFS_CTRL_B, {4'h0, 1'b1, csz[k][2], 1'b0, d[8]});
      fork
        begin
          u_usfc_peer.grab(len, bc, f1, t1);
          u_usfc_peer.grab(len, bc, f2, t2);
        end
        begin
          bus_wr(usfc_pkg::OFS_DATA, d[7:0]);
          repeat (4) @(posedge clk_sys_in);
          bus_wr(usfc_pkg::OFS_DATA, d[7:0]);
          bus_wr(usfc_pkg::OFS_CTRL_B, {5'h0, csz[k][2], 2'h0});
          `CHK(txd_oe, 1'b1)
        end
      join
      `CHK(f1, e)
      `CHK(f2, e)
      `CHK(t2 - t1 >= len * bc && t2 - t1 < len * bc + bc, 1'b1)
      repeat (bc) @(posedge clk_sys_in);
      `CHK(txd_oe, 1'b0)
    end
    bus_wr(usfc_pkg::OFS_STATUS, 8'h00);
  endtask

  // Nine-bit frames, one stop bit, good then bad parity.
  task automatic t_rx();
    logic [31:0] r;
    logic [12:0] e;
    int          len;
    bus_wr(usfc_pkg::OFS_FRAME, 8'h2e);
    bus_wr(usfc_pkg::OFS_CTRL_B, 8'h04);
    for (int bad = 0; bad < 2; bad++) begin
      e = mk(9'h13c, 9, usfc_pkg::PAR_EVEN, 1, len);
      e[10] = e[10] ^ 1'(bad);
      u_usfc_peer.send(e, len, 32);
      bus_rd(usfc_pkg::OFS_STATUS, r);
      `CHK(r & 32'h94, bad ? 32'h84 : 32'h80)
      bus_rd(usfc_pkg::OFS_CTRL_B, r);
      `CHK(r[1], 1'b1)
      bus_rd(usfc_pkg::OFS_DATA, r);
      `CHK(r, 32'h3c)
    end
  endtask

  // Reset, then scenarios.
  initial begin
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_regs();
    t_modes();
    t_tx();
    t_rx();
    complete_run();
  end
endmodule

bind usfc_usart_top usfc_chk u_usfc_chk (.clk_sys_in, .sys_rst_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
  .hrdata_out, .hreadyout_out, .hresp_out, .transmit_data_pin_out, .transmit_data_oe_out, .serial_clock_pin_out,
  .serial_clock_oe_out);

`default_nettype wire
